/* File: hw/cgc_decode.sv */
/*
 * Chip select decoder: eight memory selects from the top address bits and
 * eight port selects, either one-of-eight decoded or linear select.
 * Assumes the address is stable while selects are used; outputs registered.
 */
`timescale 1ns/1ps
module cgc_decode import cgc_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // address and mode
    input wire logic [15:0] addr,
    input wire logic linear_mode,
    // selects, active low
    output logic [7:0] mem_cs_n,
    output logic [7:0] port_cs_n
);
    // one select per entry; linear mode spends eight address bits instead of a decoder
    for (genvar i = 0; i < 8; i++) begin : g_sel
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mem_cs_n[i] <= 1'b1;
                port_cs_n[i] <= 1'b1;
            end else begin
                mem_cs_n[i] <= addr[15:13] != 3'(i);
                if (linear_mode) begin
                    port_cs_n[i] <= !addr[i];
                end else begin
                    port_cs_n[i] <= addr[7:5] != 3'(i);
                end
            end
        end
    end
endmodule

/* File: hw/cgc_phase_gen.sv */
/*
 * Two-phase clock generator: a presettable 4-bit counter stepped by a
 * 20 MHz tick, decoded into two non-overlapping phases and an early phase.
 * Assumes the system clock and synchronous active-low reset of the top.
 */
`timescale 1ns/1ps
module cgc_phase_gen import cgc_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // phase outputs
    output logic phase_one_clk,
    output logic phase_two_clk,
    output logic early_phase_one
);
    logic [3:0] tick_ff;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic ref_tick;

    // 20 MHz reference as a one-cycle tick
    always_ff @(posedge aclk) begin
        if (!aresetn || tick_ff == TICK_LAST) begin
            tick_ff <= 4'h0;
        end else begin
            tick_ff <= tick_ff + 4'h1;
        end
    end
    assign ref_tick = (tick_ff == TICK_LAST);

    // reload on terminal count gives 13 states per period
    assign nxt_cnt = (cnt_ff == CNT_TERMINAL) ? CNT_PRESET : cnt_ff + 4'h1;

    // counter and decoded phases, all stepped on the reference only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // one short of the early state: first ticks give a full early
            // pulse and a full phase one, so no runt phase after reset
            cnt_ff <= CNT_RESET;
            phase_one_clk <= 1'b0;
            phase_two_clk <= 1'b0;
            early_phase_one <= 1'b0;
        end else if (ref_tick) begin
            cnt_ff <= nxt_cnt;
            // gap states between the two ranges keep phases apart
            phase_one_clk <= nxt_cnt >= PH1_FIRST && nxt_cnt <= PH1_LAST;
            phase_two_clk <= nxt_cnt >= PH2_FIRST && nxt_cnt <= PH2_LAST;
            early_phase_one <= (nxt_cnt == EARLY_AT);
        end
    end
endmodule

/* File: hw/cgc_top.sv */
/*
 * Processor support block: phase generation, request resampling, status
 * strobe and latch, read and write strobe gating, data and address buffer
 * control, isolated or memory-mapped port decoding, AXI4-Lite registers.
 * Assumes the processor drives its status word at cycle start, that all
 * pins are synchronous to aclk, and an AXI4-Lite master on the bus side.
 * Two-way pins are split into input, output and active-low enable.
 */
`timescale 1ns/1ps
module cgc_top import cgc_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // processor clocking and handshakes
    output logic phase_one_clk,
    output logic phase_two_clk,
    output logic early_phase_one,
    input wire logic ready_req,
    input wire logic dma_req,
    output logic cpu_ready,
    output logic bus_hold_request,
    input wire logic cycle_start_marker,
    output logic status_latch_strobe_n,
    // processor control
    input wire logic read_window,
    input wire logic write_strobe_n,
    input wire logic bus_release_ctl,
    // processor side data and address
    input wire logic [7:0] cpu_data_i,
    output logic [7:0] cpu_data_o,
    output logic cpu_data_oe_n,
    input wire logic [15:0] cpu_addr,
    // system side data and address
    input wire logic [7:0] sys_data_i,
    output logic [7:0] sys_data_o,
    output logic sys_data_oe_n,
    output logic [15:0] sys_addr_o,
    output logic sys_addr_oe_n,
    output logic buffer_direction,
    // control strobes, active low
    output logic memory_read_n,
    output logic memory_write_n,
    output logic port_read_n,
    output logic port_write_n,
    output logic irq_acknowledge_n,
    output logic mapped_port_read_n,
    output logic mapped_port_write_n,
    // chip selects, active low
    output logic [7:0] mem_cs_n,
    output logic [7:0] port_cs_n
);
    logic early_d_ff;
    logic early_rise;
    logic [7:0] status_ff;
    logic mapped_ff;
    logic linear_ff;
    logic [3:0] split_ff;
    logic split_hit;
    logic port_space;
    logic rd_mem, rd_port, rd_irq;
    logic wr_mem, wr_port;
    logic aw_take, w_take, ar_take;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;

    // phase counter and decode
    cgc_phase_gen u_phase (
        .aclk(aclk),
        .aresetn(aresetn),
        .phase_one_clk(phase_one_clk),
        .phase_two_clk(phase_two_clk),
        .early_phase_one(early_phase_one)
    );

    // memory and port chip selects
    cgc_decode u_decode (
        .aclk(aclk),
        .aresetn(aresetn),
        .addr(cpu_addr),
        .linear_mode(linear_ff),
        .mem_cs_n(mem_cs_n),
        .port_cs_n(port_cs_n)
    );

    // rising edge of early phase stands in for its clock edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            early_d_ff <= 1'b0;
        end else begin
            early_d_ff <= early_phase_one;
        end
    end
    assign early_rise = early_phase_one && !early_d_ff;

    // request resampling keeps ready and hold clear of phase edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_ready <= 1'b0;
            bus_hold_request <= 1'b0;
        end else if (early_rise) begin
            cpu_ready <= ready_req;
            bus_hold_request <= dma_req;
        end
    end

    // status strobe and latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_latch_strobe_n <= 1'b1;
            status_ff <= 8'h00;
        end else begin
            status_latch_strobe_n <= !(early_phase_one && cycle_start_marker);
            if (!status_latch_strobe_n) begin
                status_ff <= cpu_data_i;
            end
        end
    end

    // split bit picks memory or port space in mapped mode
    assign split_hit = cpu_addr[split_ff];
    assign port_space = mapped_ff && split_hit;
    assign rd_mem = status_ff[ST_MEM_READ] && read_window;
    assign rd_port = status_ff[ST_INPUT] && read_window;
    assign rd_irq = status_ff[ST_IRQ_ACK] && read_window;
    assign wr_mem = !status_ff[ST_MEM_READ] && !status_ff[ST_OUTPUT]
        && !write_strobe_n;
    assign wr_port = status_ff[ST_OUTPUT] && !write_strobe_n;

    // strobes held inactive while another master owns the bus
    always_ff @(posedge aclk) begin
        if (!aresetn || bus_release_ctl) begin
            memory_read_n <= 1'b1;
            memory_write_n <= 1'b1;
            port_read_n <= 1'b1;
            port_write_n <= 1'b1;
            irq_acknowledge_n <= 1'b1;
            mapped_port_read_n <= 1'b1;
            mapped_port_write_n <= 1'b1;
        end else begin
            memory_read_n <= !(rd_mem && !port_space);
            memory_write_n <= !(wr_mem && !port_space);
            port_read_n <= !rd_port;
            port_write_n <= !wr_port;
            irq_acknowledge_n <= !rd_irq;
            mapped_port_read_n <= !(rd_mem && port_space);
            mapped_port_write_n <= !(wr_mem && port_space);
        end
    end

    // data and address buffers; release is sampled every aclk, not per phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_data_o <= 8'h00;
            sys_data_o <= 8'h00;
            cpu_data_oe_n <= 1'b1;
            sys_data_oe_n <= 1'b1;
            sys_addr_o <= 16'h0000;
            sys_addr_oe_n <= 1'b1;
            buffer_direction <= 1'b0;
        end else begin
            cpu_data_o <= sys_data_i;
            sys_data_o <= cpu_data_i;
            buffer_direction <= read_window;
            cpu_data_oe_n <= bus_release_ctl || !read_window;
            sys_data_oe_n <= bus_release_ctl || read_window;
            sys_addr_o <= cpu_addr;
            sys_addr_oe_n <= bus_release_ctl;
        end
    end

    // axi write channel: address and data taken in either order
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_take) begin
                s_axi_awready <= 1'b0;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                s_axi_wready <= 1'b0;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                if (awaddr_ff == REG_CTRL || awaddr_ff == REG_STATUS) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control register; status word offset accepts writes and ignores them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mapped_ff <= 1'b0;
            linear_ff <= 1'b0;
            split_ff <= SPLIT_RESET;
        end else if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid
                     && awaddr_ff == REG_CTRL) begin
            if (wstrb_ff[0]) begin
                mapped_ff <= wdata_ff[CTRL_MAPPED];
                linear_ff <= wdata_ff[CTRL_LINEAR];
            end
            if (wstrb_ff[1]) begin
                split_ff <= wdata_ff[CTRL_SPLIT_LO +: 4];
            end
        end
    end

    // axi read channel: one read at a time, data from a register
    assign ar_take = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr == REG_CTRL) begin
                s_axi_rdata <= {20'h00000, split_ff, 6'h00, linear_ff,
                    mapped_ff};
            end else if (s_axi_araddr == REG_STATUS) begin
                s_axi_rdata <= {18'h00000, bus_release_ctl,
                    bus_hold_request, cpu_ready, early_phase_one,
                    phase_two_clk, phase_one_clk, status_ff};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks on the driven side
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    phase_no_overlap_a: assert property (
        !(phase_one_clk && phase_two_clk))
        else $error("phases overlap");
    phase_period_a: assert property (
        $rose(phase_one_clk) |-> ##130 $rose(phase_one_clk))
        else $error("phase period is not 13 reference ticks");
    early_leads_a: assert property (
        $fell(early_phase_one) |-> $rose(phase_one_clk))
        else $error("early phase does not lead phase one");
    ready_sample_a: assert property (
        early_rise |=> cpu_ready == $past(ready_req))
        else $error("ready not resampled on early phase");
    strobe_cause_a: assert property (
        !status_latch_strobe_n |-> $past(early_phase_one)
            && $past(cycle_start_marker))
        else $error("status strobe without early phase and cycle start");
    latch_capture_a: assert property (
        !status_latch_strobe_n ##1 status_latch_strobe_n
            |-> status_ff == $past(cpu_data_i))
        else $error("status word not captured on strobe");
    read_in_window_a: assert property (
        !memory_read_n || !port_read_n || !irq_acknowledge_n
            |-> $past(read_window))
        else $error("read strobe outside read window");
    write_gated_a: assert property (
        !memory_write_n || !port_write_n |-> !$past(write_strobe_n))
        else $error("write strobe without processor write strobe");
    mapped_split_a: assert property (
        port_space && rd_mem && !bus_release_ctl
            |=> memory_read_n && !mapped_port_read_n)
        else $error("memory read not diverted to port space");
    release_float_a: assert property (
        bus_release_ctl |=> cpu_data_oe_n && sys_data_oe_n && sys_addr_oe_n)
        else $error("buffers driven during bus release");
    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
    hold_sample_a: assert property (
        early_rise |=> bus_hold_request == $past(dma_req))
        else $error("hold request not resampled on early phase");
    dir_follow_a: assert property (
        read_window |=> buffer_direction)
        else $error("buffer not turned toward processor in read window");
    addr_pass_a: assert property (
        !bus_release_ctl |=> !sys_addr_oe_n && sys_addr_o == $past(cpu_addr))
        else $error("address not passed while bus is held");
    irq_window_a: assert property (
        !irq_acknowledge_n |-> $past(status_ff[ST_IRQ_ACK])
            && $past(read_window))
        else $error("interrupt acknowledge outside its status cycle");
    port_write_a: assert property (
        !port_write_n |-> $past(status_ff[ST_OUTPUT]))
        else $error("port write without output status");
    mapped_write_a: assert property (
        !mapped_port_write_n |-> $past(mapped_ff) && $past(split_hit))
        else $error("mapped port write outside port space");
    linear_sel_a: assert property (
        linear_ff |=> port_cs_n == ~$past(cpu_addr[7:0]))
        else $error("linear port select does not follow its address bit");
    mem_select_a: assert property (
        !mem_cs_n[0] |-> $past(cpu_addr[15:13]) == 3'h0)
        else $error("memory select zero outside its address block");

    mem_read_c: cover property (!memory_read_n);
    port_write_c: cover property (!port_write_n);
    mapped_read_c: cover property (!mapped_port_read_n);
    release_c: cover property (bus_release_ctl ##1 sys_addr_oe_n);
    mapped_write_c: cover property (!mapped_port_write_n);
endmodule

/* File: pkg/cgc_pkg.sv */
/*
 * Shared constants for the processor clock and bus control block:
 * clock figures, phase counter decode, status word bit positions and the
 * register map seen over the AXI4-Lite slave.
 * Assumes a single 200 MHz system clock from which the 20 MHz reference
 * is derived by a tick divider.
 */
package cgc_pkg;
    // clock figures
    localparam int CLK_HZ = 200_000_000;
    localparam int REF_HZ = 20_000_000;
    localparam int TICK_DIV = CLK_HZ / REF_HZ;
    localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);
    // phase counter decode
    localparam logic [3:0] CNT_PRESET = 4'h3;
    localparam logic [3:0] CNT_RESET = 4'he;
    localparam logic [3:0] CNT_TERMINAL = 4'hf;
    localparam logic [3:0] PH1_FIRST = 4'h3;
    localparam logic [3:0] PH1_LAST = 4'h4;
    localparam logic [3:0] PH2_FIRST = 4'h6;
    localparam logic [3:0] PH2_LAST = 4'hc;
    localparam logic [3:0] EARLY_AT = 4'hf;
    // status word bit positions
    localparam int ST_IRQ_ACK = 0;
    localparam int ST_OUTPUT = 4;
    localparam int ST_INPUT = 6;
    localparam int ST_MEM_READ = 7;
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CTRL_MAPPED = 0;
    localparam int CTRL_LINEAR = 1;
    localparam int CTRL_SPLIT_LO = 8;
    localparam logic [3:0] SPLIT_RESET = 4'hf;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: sim/cgc_cpu_model.sv */
/*
 * Processor core stand-in: raises its cycle start marker with the early
 * phase, shows its status word, then opens a read window or a write strobe
 * during phase two. Assumes the phase outputs of the block under test and
 * per-cycle commands from the bench, changed only between cycles.
 */
`timescale 1ns/1ps
module cgc_cpu_model (
    // clock and phases
    input wire logic aclk,
    input wire logic early_phase_one,
    input wire logic phase_two_clk,
    // bench commands
    input wire logic go,
    input wire logic [7:0] st_word,
    input wire logic is_rd,
    input wire logic is_wr,
    // processor pins
    output logic cycle_start_marker,
    output logic [7:0] cpu_data_i,
    output logic read_window,
    output logic write_strobe_n
);
    logic [1:0] hold_ff = 2'h0;

    initial begin
        cycle_start_marker = 1'b0;
        cpu_data_i = 8'h00;
        read_window = 1'b0;
        write_strobe_n = 1'b1;
    end

    // status word stands with the marker and two cycles after it; outside
    // that the lines toggle so a late latch never sees a stale match
    always @(posedge aclk) begin
        cycle_start_marker <= go & early_phase_one;
        if (go & early_phase_one)
            hold_ff <= 2'h2;
        else if (hold_ff != 2'h0)
            hold_ff <= hold_ff - 2'h1;
        if ((go & early_phase_one) | (hold_ff != 2'h0))
            cpu_data_i <= st_word;
        else
            cpu_data_i <= ~cpu_data_i;
        read_window <= go & is_rd & phase_two_clk;
        write_strobe_n <= !(go & is_wr & phase_two_clk);
    end
endmodule

/* File: sim/cpu_group_clock_and_bus_control_test.sv */
/*
 * Self-checking bench: drives the block through AXI4-Lite and a processor
 * model, and compares the strobe, buffer and select outputs each cycle, and the data outputs while driven, with a bench model.
 * Assumes a 200 MHz aclk and synchronous active-low reset.
 */
`timescale 1ns/1ps
module cpu_group_clock_and_bus_control_test import cgc_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic ph1, ph2, early, cpu_ready, hold, marker, stb_n, rw, wr_n;
    logic ready_req = 1'b1, dma_req = 1'b0, rel = 1'b0;
    logic [7:0] cdi, cdo, sdo, mcs, pcs, sdi = 8'h00, st = 8'h00;
    logic coe, soe, aoe, bdir, mr, mw, pr, pw, ia, mpr, mpw;
    logic [15:0] saddr, caddr = 16'h0;
    logic go = 1'b0, is_rd = 1'b0, is_wr = 1'b0, mon = 1'b0;
    logic mapped = 1'b0, linear = 1'b0;
    logic [3:0] split = 4'hf;
    logic m_map = 1'b0, m_lin = 1'b0;
    logic [3:0] m_spl = 4'hf;
    logic [7:0] e_st = 8'h00;
    logic e_stb = 1'b1;
    logic [2:0] e_r = 3'h7;
    logic [1:0] e_w = 2'h3, e_m = 2'h3;
    logic [3:0] e_b = 4'h7;
    logic [31:0] e_d = 32'h0;
    logic [15:0] e_cs = 16'hffff;
    logic p1q = 1'b0, p2q = 1'b0, eq = 1'b0, seen = 1'b0, seen_e = 1'b0;
    int c1 = 0, c2 = 0, ce = 0, per = 0;
    int errors = 0;
    int checks = 0;

    cgc_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .phase_one_clk(ph1), .phase_two_clk(ph2), .early_phase_one(early),
        .ready_req(ready_req), .dma_req(dma_req), .cpu_ready(cpu_ready),
        .bus_hold_request(hold), .cycle_start_marker(marker),
        .status_latch_strobe_n(stb_n), .read_window(rw),
        .write_strobe_n(wr_n), .bus_release_ctl(rel),
        .cpu_data_i(cdi), .cpu_data_o(cdo), .cpu_data_oe_n(coe),
        .cpu_addr(caddr), .sys_data_i(sdi), .sys_data_o(sdo),
        .sys_data_oe_n(soe), .sys_addr_o(saddr), .sys_addr_oe_n(aoe),
        .buffer_direction(bdir), .memory_read_n(mr), .memory_write_n(mw),
        .port_read_n(pr), .port_write_n(pw), .irq_acknowledge_n(ia),
        .mapped_port_read_n(mpr), .mapped_port_write_n(mpw),
        .mem_cs_n(mcs), .port_cs_n(pcs));

    cgc_cpu_model cpu (.aclk(aclk), .early_phase_one(early),
        .phase_two_clk(ph2), .go(go), .st_word(st), .is_rd(is_rd),
        .is_wr(is_wr), .cycle_start_marker(marker), .cpu_data_i(cdi),
        .read_window(rw), .write_strobe_n(wr_n));

    always #2.5 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic final_report;
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one write; address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        // an edge first, so back-to-back calls never drive bready twice
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        chk(32'({bvalid, bresp}), 32'({1'b1, er}), "write response");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] msk,
                      input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        // an edge first, so back-to-back calls never drive rready twice
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        chk(32'({rvalid, rresp}), 32'({1'b1, er}), "read response");
        chk(rdata & msk, ed, "read data");
    endtask

    // one machine cycle: release may hit the running transfer at phase two,
    // then the next cycle's command is set up while phase two is low
    task automatic cyc(input logic r, input logic w, input logic b);
        do @(posedge aclk); while (!ph2);
        rel <= b;
        do @(posedge aclk); while (ph2);
        rel <= 1'b0;
        go <= r | w;
        is_rd <= r;
        is_wr <= w;
        st <= 8'($urandom);
        caddr <= 16'($urandom);
        sdi <= 8'($urandom);
        ready_req <= 1'($urandom);
        dma_req <= 1'($urandom);
    endtask

    // bench model of the strobe, buffer, data and select outputs, from inputs before the edge
    always @(posedge aclk) begin
        logic hi, mrx, mwx;
        // mode copies switch at the edge that sees the control write
        // answered, one edge after the design's register took it
        if (bvalid && bready && awaddr == REG_CTRL) begin
            m_map = wdata[CTRL_MAPPED];
            m_lin = wdata[CTRL_LINEAR];
            m_spl = wdata[CTRL_SPLIT_LO +: 4];
        end
        hi = m_map & caddr[m_spl];
        mrx = rw & e_st[ST_MEM_READ] & !rel;
        mwx = !wr_n & !e_st[ST_MEM_READ] & !e_st[ST_OUTPUT] & !rel;
        e_r <= {!(mrx & !hi), !(rw & e_st[ST_INPUT] & !rel),
                !(rw & e_st[ST_IRQ_ACK] & !rel)};
        e_w <= {!(mwx & !hi), !(!wr_n & e_st[ST_OUTPUT] & !rel)};
        e_m <= {!(mrx & hi), !(mwx & hi)};
        e_b <= {rw, !(rw & !rel), !(!rw & !rel), rel};
        e_d <= {sdi, cdi, caddr};
        e_cs[15:8] <= ~(8'h1 << caddr[15:13]);
        e_cs[7:0] <= m_lin ? ~caddr[7:0] : ~(8'h1 << caddr[7:5]);
        if (!e_stb) e_st <= cdi;
        e_stb <= !(early & marker);
    end

    // compare in mid-cycle, where the design's updates have settled
    always @(negedge aclk) if (mon) begin
        chk(32'(stb_n), 32'(e_stb), "status strobe");
        chk(32'({mr, pr, ia}), 32'(e_r), "read strobes");
        chk(32'({mw, pw}), 32'(e_w), "write strobes");
        chk(32'({mpr, mpw}), 32'(e_m), "mapped strobes");
        chk(32'({bdir, coe, soe, aoe}), 32'(e_b), "buffers");
        chk(32'({mcs, pcs}), 32'(e_cs), "selects");
        if (!coe) chk(32'(cdo), 32'(e_d[31:24]), "to processor");
        if (!soe) chk(32'(sdo), 32'(e_d[23:16]), "to system");
        if (!aoe) chk(32'(saddr), 32'(e_d[15:0]), "address");
        chk(32'(ph1 & ph2), 32'h0, "phase overlap");
        per++;
        if (ph1 && !p1q) begin
            if (seen) chk(32'(per), 32'd130, "period");
            chk(32'({eq, early}), 32'h2, "early lead");
            per = 0;
            seen = 1'b1;
        end
        if (ph2 && !p2q && seen_e)
            chk(32'({cpu_ready, hold}), 32'({ready_req, dma_req}), "req");
        if (ph1) c1++;
        else if (p1q) begin
            chk(32'(c1), 32'd20, "phase one width");
            c1 = 0;
        end
        if (ph2) c2++;
        else if (p2q) begin
            chk(32'(c2), 32'd70, "phase two width");
            c2 = 0;
        end
        if (early) ce++;
        else if (eq) begin
            chk(32'(ce), 32'd10, "early width");
            ce = 0;
            seen_e = 1'b1;
        end
        p1q = ph1;
        p2q = ph2;
        eq = early;
    end

    initial begin
        logic [31:0] k;
        void'($urandom(32'hbc02));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        mon <= 1'b1;
        rd(REG_CTRL, 32'hffffffff, 32'h00000f00, RESP_OKAY);
        rd(8'h08, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(8'h08, 32'h3, RESP_SLVERR);
        wr(REG_STATUS, 32'hffff, RESP_OKAY);
        rd(REG_CTRL, 32'hffffffff, 32'h00000f00, RESP_OKAY);
        // isolated, mapped, linear, then mapped on a random split bit, without and then with linear
        for (int m = 0; m < 5; m++) begin
            mapped = (m == 1 || m >= 3);
            linear = (m == 2 || m == 4);
            split = (m < 3) ? 4'hf : 4'($urandom);
            wr(REG_CTRL, {20'h0, split, 6'h0, linear, mapped}, RESP_OKAY);
            rd(REG_CTRL, 32'h00000f03, {20'h0, split, 6'h0, linear, mapped},
               RESP_OKAY);
            for (int i = 0; i < 12; i++) begin
                k = $urandom;
                cyc(k[0], !k[0], k[2] & k[1]);
                rd(REG_STATUS, 32'hff, 32'(e_st), RESP_OKAY);
            end
            cyc(1'b0, 1'b0, 1'b0);
        end
        final_report;
    end

    // watchdog well beyond the roughly 9000 cycles the run needs
    initial begin
        #200000;
        errors++;
        final_report;
    end
endmodule
